// [hdl/dal_pkg.sv]
// constants for the dma channel address limit block
package dal_pkg;
  localparam int          ADDR_W        = 24;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  OFF_START     = 8'h04;
  localparam logic [7:0]  OFF_LIMIT     = 8'h08;
  localparam logic [7:0]  OFF_DEV       = 8'h0c;
  localparam logic [7:0]  OFF_CTRL      = 8'h10;
  localparam logic [7:0]  OFF_STATUS    = 8'h14;
  localparam logic [7:0]  OFF_MASK      = 8'h18;
  localparam logic [7:0]  OFF_CRC_EN    = 8'h20;
  localparam int          CTRL_INC_MEM  = 16;
  localparam int          CTRL_INC_DEV  = 17;
  localparam int          CTRL_SIZE_LO  = 20;
  localparam int          CTRL_ABORT    = 25;
  localparam int          ST_DONE       = 0;
  localparam int          ST_TERM       = 1;
  localparam int          ST_ABORT      = 2;
  localparam int          ST_W          = 3;
  localparam logic [23:0] ADDR_RST      = 24'h000000;
  localparam logic [2:0]  SIZE_RST      = 3'h0;
  localparam int          CHAN_NUM      = 0;
endpackage

// [hdl/dal_adder.sv]
// address advance by packet size, optional per enable
`timescale 1ns/1ps
module dal_adder (
  input  wire logic [23:0] addr_in,
  input  wire logic [2:0]  size,
  input  wire logic        inc_en,
  output logic      [23:0] addr_out
);
  always_comb begin
    if (inc_en) begin
      addr_out = addr_in + {21'h0, size};
    end else begin
      addr_out = addr_in;
    end
  end
endmodule

// [hdl/dal_irq.sv]
// sticky status bits with write-one-to-clear and mask
`timescale 1ns/1ps
module dal_irq (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [2:0] set_ev,
  input  wire logic [2:0] clr_w1c,
  input  wire logic [2:0] mask,
  output logic      [2:0] status_ff,
  output logic            irq_ff
);
  always_ff @(posedge clk) begin
    if (rst) begin
      status_ff <= 3'h0;
    end else if (ce) begin
      status_ff <= (status_ff & ~clr_w1c) | set_ev;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= |(((status_ff & ~clr_w1c) | set_ev) & mask);
    end
  end
endmodule

// [hdl/dal_top.sv]
// dma channel address tracking with limit compare and apb registers
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// What this block does
// - limit bounds transfer only with memory increment
// - memory address equals limit ends, flags done
// - addresses 24 bits wide, upper bits reserved
// - device address drives master peripheral bus
// - device address advances by size if enabled
// - crc exists on channel zero only
// - memory address advances by size if enabled
// - no memory increment means no self-ending
module dal_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        xfer_active,
  input  wire logic        pkt_done,
  input  wire logic        flow_term,
  output logic      [23:0] mem_addr,
  output logic      [23:0] dev_addr,
  output logic             xfer_end,
  output logic             irq
);
  logic [23:0] start_ff;
  logic [23:0] limit_ff;
  logic [23:0] dev_ff;
  logic        inc_mem_ff;
  logic        inc_dev_ff;
  logic [2:0]  size_ff;
  logic        abort_ff;
  logic [2:0]  mask_ff;
  logic        crc_en_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        end_ff;
  logic [23:0] nxt_start;
  logic [23:0] nxt_dev;
  logic [2:0]  status;
  logic        irq_w;
  logic [2:0]  ev;
  logic [2:0]  w1c;
  logic        acc;
  logic        wr;
  logic        hit_limit;
  logic        adv;
  logic        map_ok;

  assign acc = psel & penable & ~pready_ff;
  assign wr  = acc & pwrite;
  assign adv = xfer_active & pkt_done & ~end_ff;

  always_comb begin
    unique case (paddr)
      dal_pkg::OFF_START, dal_pkg::OFF_LIMIT, dal_pkg::OFF_DEV,
      dal_pkg::OFF_CTRL, dal_pkg::OFF_STATUS, dal_pkg::OFF_MASK,
      dal_pkg::OFF_CRC_EN: map_ok = 1'b1;
      default: map_ok = 1'b0;
    endcase
  end

  dal_adder u_mem_add (
    .addr_in  (start_ff),
    .size     (size_ff),
    .inc_en   (inc_mem_ff & adv),
    .addr_out (nxt_start)
  );

  dal_adder u_dev_add (
    .addr_in  (dev_ff),
    .size     (size_ff),
    .inc_en   (inc_dev_ff & adv),
    .addr_out (nxt_dev)
  );

  // limit compare on the updated address, only with increment on
  assign hit_limit = adv & inc_mem_ff
                   & (nxt_start == limit_ff);

  assign ev  = {abort_ff & xfer_active & ~end_ff,
                flow_term & xfer_active & ~end_ff,
                hit_limit};
  assign w1c = (wr && paddr == dal_pkg::OFF_STATUS) ? pwdata[2:0] : 3'h0;

  dal_irq u_irq (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .set_ev    (ev),
    .clr_w1c   (w1c),
    .mask      (mask_ff),
    .status_ff (status),
    .irq_ff    (irq_w)
  );

  // memory address register, hardware advance wins over write
  always_ff @(posedge clk) begin
    if (rst) begin
      start_ff <= dal_pkg::ADDR_RST;
    end else if (ce) begin
      if (adv) begin
        start_ff <= nxt_start;
      end else if (wr && paddr == dal_pkg::OFF_START) begin
        start_ff <= pwdata[23:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      limit_ff <= dal_pkg::ADDR_RST;
    end else if (ce && wr && paddr == dal_pkg::OFF_LIMIT) begin
      limit_ff <= pwdata[23:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dev_ff <= dal_pkg::ADDR_RST;
    end else if (ce) begin
      if (adv) begin
        dev_ff <= nxt_dev;
      end else if (wr && paddr == dal_pkg::OFF_DEV) begin
        dev_ff <= pwdata[23:0];
      end
    end
  end

  // control fields; abort self-clears while the transfer end flag is set
  always_ff @(posedge clk) begin
    if (rst) begin
      inc_mem_ff <= 1'b0;
      inc_dev_ff <= 1'b0;
      size_ff    <= dal_pkg::SIZE_RST;
      abort_ff   <= 1'b0;
    end else if (ce) begin
      if (wr && paddr == dal_pkg::OFF_CTRL) begin
        inc_mem_ff <= pwdata[dal_pkg::CTRL_INC_MEM];
        inc_dev_ff <= pwdata[dal_pkg::CTRL_INC_DEV];
        size_ff    <= pwdata[dal_pkg::CTRL_SIZE_LO +: 3];
        abort_ff   <= pwdata[dal_pkg::CTRL_ABORT];
      end else if (end_ff) begin
        abort_ff   <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_ff   <= 3'h0;
      crc_en_ff <= 1'b0;
    end else if (ce && wr) begin
      if (paddr == dal_pkg::OFF_MASK) begin
        mask_ff <= pwdata[2:0];
      end
      if (paddr == dal_pkg::OFF_CRC_EN && dal_pkg::CHAN_NUM == 0) begin
        crc_en_ff <= pwdata[0];
      end
    end
  end

  // transfer end holds until the engine drops active
  always_ff @(posedge clk) begin
    if (rst) begin
      end_ff <= 1'b0;
    end else if (ce) begin
      if (!xfer_active) begin
        end_ff <= 1'b0;
      end else if (|ev) begin
        end_ff <= 1'b1;
      end
    end
  end

  // apb slave: one wait state, error on unmapped offsets
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else if (ce) begin
      pready_ff  <= acc;
      pslverr_ff <= acc & ~map_ok;
      if (acc && !pwrite) begin
        unique case (paddr)
          dal_pkg::OFF_START:  prdata_ff <= {8'h00, start_ff};
          dal_pkg::OFF_LIMIT:  prdata_ff <= {8'h00, limit_ff};
          dal_pkg::OFF_DEV:    prdata_ff <= {8'h00, dev_ff};
          dal_pkg::OFF_CTRL:   prdata_ff <= {6'h00, abort_ff, 2'h0,
                                             size_ff, 2'h0, inc_dev_ff,
                                             inc_mem_ff, 16'h0000};
          dal_pkg::OFF_STATUS: prdata_ff <= {29'h0, status};
          dal_pkg::OFF_MASK:   prdata_ff <= {29'h0, mask_ff};
          dal_pkg::OFF_CRC_EN: prdata_ff <= {31'h0, crc_en_ff};
          default:             prdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign mem_addr = start_ff;
  assign dev_addr = dev_ff;
  assign xfer_end = end_ff;
  assign irq      = irq_w;

  // address, limit and end checks
  a_done_on_limit: assert property (
    @(posedge clk) disable iff (rst)
    (ce && hit_limit) |=> (status[dal_pkg::ST_DONE] && end_ff))
    else $error("done not flagged at limit");

  a_no_inc_no_done: assert property (
    @(posedge clk) disable iff (rst)
    (ce && !inc_mem_ff) |=> !$rose(status[dal_pkg::ST_DONE]))
    else $error("done without memory increment");

  a_mem_advance: assert property (
    @(posedge clk) disable iff (rst)
    (ce && adv && inc_mem_ff) |=>
      (mem_addr == $past(start_ff) + {21'h0, $past(size_ff)}))
    else $error("memory address did not advance");

  a_mem_hold: assert property (
    @(posedge clk) disable iff (rst)
    (ce && adv && !inc_mem_ff) |=> $stable(mem_addr))
    else $error("memory address moved without increment");

  a_dev_advance: assert property (
    @(posedge clk) disable iff (rst)
    (ce && adv && inc_dev_ff) |=>
      (dev_addr == $past(dev_ff) + {21'h0, $past(size_ff)}))
    else $error("device address did not advance");

  a_dev_hold: assert property (
    @(posedge clk) disable iff (rst)
    (ce && adv && !inc_dev_ff) |=> $stable(dev_addr))
    else $error("device address moved without increment");

  a_limit_gate: assert property (
    @(posedge clk) disable iff (rst)
    (ce && adv && !inc_mem_ff && !flow_term && !abort_ff) |=> !xfer_end)
    else $error("limit used without memory increment");

  a_same_cycle: assert property (
    @(posedge clk) disable iff (rst)
    (ce && adv && inc_mem_ff && nxt_start == limit_ff) |=>
      (xfer_end && mem_addr == $past(limit_ff)))
    else $error("limit equality not flagged at once");

  a_end_blocks_pkt: assert property (
    @(posedge clk) disable iff (rst)
    (ce && end_ff && pkt_done && !wr) |=>
      ($stable(mem_addr) && $stable(dev_addr)))
    else $error("packet taken after transfer end");

  a_term_ends: assert property (
    @(posedge clk) disable iff (rst)
    (ce && flow_term && xfer_active && !end_ff) |=>
      (status[dal_pkg::ST_TERM] && end_ff))
    else $error("flow control end not taken");

  a_abort_ends: assert property (
    @(posedge clk) disable iff (rst)
    (ce && abort_ff && xfer_active && !end_ff) |=>
      (status[dal_pkg::ST_ABORT] && end_ff))
    else $error("abort did not end transfer");

  // register, interrupt and clock enable checks
  a_upper_zero: assert property (
    @(posedge clk) disable iff (rst)
    (ce && acc && !pwrite && (paddr == dal_pkg::OFF_START ||
      paddr == dal_pkg::OFF_LIMIT || paddr == dal_pkg::OFF_DEV)) |=>
      (prdata[31:24] == 8'h00))
    else $error("reserved address bits not zero");

  a_done_clear: assert property (
    @(posedge clk) disable iff (rst)
    (ce && wr && paddr == dal_pkg::OFF_STATUS && pwdata[0] && !ev[0]) |=>
      !status[dal_pkg::ST_DONE])
    else $error("done bit not cleared by write");

  a_irq_level: assert property (
    @(posedge clk) disable iff (rst)
    ce |=> (irq == |(status & $past(mask_ff))))
    else $error("interrupt level wrong");

  a_ce_freeze: assert property (
    @(posedge clk) disable iff (rst)
    !ce |=> ($stable(mem_addr) && $stable(dev_addr) &&
      $stable(xfer_end) && $stable(irq)))
    else $error("state moved with clock enable low");

  a_apb_answer: assert property (
    @(posedge clk) disable iff (rst)
    (ce && psel && penable && !pready) |=> pready)
    else $error("apb access not answered");
endmodule

// [tb/dal_periph.sv]
// partner model: flow-controlling master peripheral
`timescale 1ns/1ps
module dal_periph (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic req,
  input  wire logic term,
  output logic      xfer_active,
  output logic      pkt_done,
  output logic      flow_term
);
  // one packet pulse per request, only while a transfer runs
  // a non-smbus peripheral on channel 0; smbus would use 1-6
  always @(posedge clk) begin
    xfer_active <= run;
    pkt_done    <= req & run;
    flow_term   <= term & run;
  end
endmodule

// [tb/testbench.sv]
// self-checking bench for the address limit block
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        run, req, term, xfer_active, pkt_done, flow_term;
  logic        ce;
  logic [23:0] mem_addr, dev_addr;
  logic        xfer_end, irq;
  int          bad_count, checks_done, cyc, mem, lim, dev, sz;
  int          incm, incd, ended, i, k;

  dal_top dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xfer_active(xfer_active), .pkt_done(pkt_done),
    .flow_term(flow_term), .mem_addr(mem_addr), .dev_addr(dev_addr),
    .xfer_end(xfer_end), .irq(irq));
  dal_periph periph (.clk(clk), .run(run), .req(req), .term(term),
    .xfer_active(xfer_active), .pkt_done(pkt_done),
    .flow_term(flow_term));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pkt();
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (3) @(posedge clk);
    if (ended == 0) begin
      mem   = mem + incm * sz;
      dev   = dev + incd * sz;
      ended = (incm != 0 && mem == lim);
    end
    @(negedge clk);
    check(32'(mem_addr), mem);
    check(32'(dev_addr), dev);
    check(32'(xfer_end), ended);
    @(posedge clk);
  endtask

  task automatic flags(input int st, input logic ir);
    apb(1'b0, dal_pkg::OFF_STATUS, 32'h0);
    check(rd, st);
    @(negedge clk);
    check(32'(irq), 32'(ir));
    @(posedge clk);
    apb(1'b1, dal_pkg::OFF_STATUS, 32'h7);
    run <= 1'b0;
    @(negedge clk);
    check(32'(irq), 32'h0);
    repeat (3) @(posedge clk);
  endtask

  initial begin
    seed = 32'd14892;
    {rst, ce} = 2'h3;
    {psel, penable, pwrite, run, req, term} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, dal_pkg::OFF_LIMIT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, dal_pkg::OFF_DEV, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, dal_pkg::OFF_LIMIT, 32'hffffffff);
    apb(1'b0, dal_pkg::OFF_LIMIT, 32'h0);
    check(rd, 32'h00ffffff);
    apb(1'b0, 8'h1c, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b1, dal_pkg::OFF_CRC_EN, 32'h1);
    apb(1'b0, dal_pkg::OFF_CRC_EN, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, dal_pkg::OFF_MASK, 32'h1);
    for (k = 0; k < 4; k++) begin
      sz    = (k == 3) ? 4 : (1 << k);
      incm  = (k < 3);
      incd  = (k < 3);
      ended = 0;
      mem   = rnd() & 32'h007ffffc;
      dev   = rnd() & 32'h007ffffc;
      lim   = incm ? mem + 3 * sz : mem + sz;
      apb(1'b1, dal_pkg::OFF_START, mem);
      apb(1'b1, dal_pkg::OFF_LIMIT, lim);
      apb(1'b1, dal_pkg::OFF_DEV, dev);
      apb(1'b1, dal_pkg::OFF_CTRL, (incm << 16) | (incd << 17) | (sz << 20));
      run <= 1'b1;
      if (k == 0) begin
        ce  <= 1'b0;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(32'(mem_addr), mem);
        check(32'(dev_addr), dev);
        @(posedge clk);
        ce  <= 1'b1;
      end
      for (i = 0; i < 4; i++) pkt();
      if (k == 3) begin
        term <= 1'b1;
        @(posedge clk);
        term <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(32'(xfer_end), 32'h1);
        @(posedge clk);
        flags(2, 1'b0);
      end else flags(1, 1'b1);
    end
    apb(1'b1, dal_pkg::OFF_CTRL, 32'h02000000);
    run <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(32'(xfer_end), 32'h1);
    @(posedge clk);
    flags(4, 1'b0);
    print_verdict();
  end
endmodule
